/* verilog/acq_pkg.sv */
package acq_pkg;

  // register map, 8-bit data, 4-bit index
  localparam logic [3:0] ADDR_CFG     = 4'h0;
  localparam logic [3:0] ADDR_REF_DIV = 4'h1;
  localparam logic [3:0] ADDR_VCO_DIV = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;

  // configuration fields
  localparam int CFG_HFCE_BIT = 0;
  localparam int CFG_LOCK_LSB = 1;
  localparam int CFG_LOCK_MSB = 2;

  localparam logic [7:0] CFG_RESET     = 8'h07;
  localparam logic [7:0] REF_DIV_RESET = 8'h00;
  localparam logic [7:0] VCO_DIV_RESET = 8'h35;

  // velocity lock lengths in window periods
  localparam logic [6:0] VLOCK_T0 = 7'h3c;
  localparam logic [6:0] VLOCK_T1 = 7'h48;
  localparam logic [6:0] VLOCK_T2 = 7'h54;
  localparam logic [6:0] VLOCK_T3 = 7'h60;

  // mark detector timing in window periods; PUMP_COUNT counts charge pump pulses for the sequencer
  localparam logic [7:0] MARK_GAP   = 8'h0c;
  localparam logic [7:0] HF_MAX     = 8'h03;
  localparam logic [1:0] HF_NEEDED  = 2'h3;
  localparam logic [1:0] PUMP_COUNT = 2'h2;

  // framing pattern: three consecutive 001 groups
  localparam logic [8:0] SYNC_PATTERN = 9'h049;

  // longest rclk pause, counted in cycles of the clock being switched to
  localparam logic [3:0] PAUSE_MAX = 4'h2;

  typedef enum {S_IDLE, S_VLOCK, S_PUMP, S_TRACK} acq_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic       read_gate;
    logic       mark_search_enable;
    logic       sync_write_gate;
    logic       encoder_enable;
    logic       raw_data;
    logic       crystal_input;
    logic       synth_vco;
    logic       pump_pulse;
    logic       synth_nrz_clk;
    logic       sync_nrz_clk;
  } pins_t;

endpackage

/* verilog/prog_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module prog_divider
  import acq_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] count,
  output var  logic         pulse_q
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         pulse_d;

  // ratio is count plus one, so 8 bits reach 256
  always_comb begin
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (tick) begin
      if (cnt_q >= count) begin
        cnt_d   = '0;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

endmodule // prog_divider

`default_nettype wire

/* verilog/read_acquisition_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module read_acquisition_sequencer
  import acq_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire bus_req_t   bus,
  output var  logic [7:0] rdata_q,
  input  wire pins_t      pins,
  output var  logic       mark_found_q,
  output var  logic       phase_only_q,
  output var  logic       low_gain_q,
  output var  logic       rclk_q,
  output var  logic       read_data_q,
  output var  logic       framed_q,
  output var  logic       ref_div_pulse,
  output var  logic       vco_div_pulse
);

  if (DIV_W != 8) begin : g_chk
    $error("divider width must be 8");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NP = $bits(pins_t);
  logic [NP-1:0] s1_q;
  logic [NP-1:0] s2_q;
  logic [NP-1:0] s3_q;
  pins_t         p;
  pins_t         pp;

  for (genvar i = 0; i < NP; i++) begin : g_sync
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end
  end

  assign p  = s2_q;
  assign pp = s3_q;

  logic rg_rise;
  logic rg_fall;
  logic raw_pulse;
  logic xtal_rise;
  logic vco_rise;
  logic pump_rise;

  assign rg_rise   = p.read_gate & ~pp.read_gate;
  assign rg_fall   = ~p.read_gate & pp.read_gate;
  assign raw_pulse = p.raw_data & ~pp.raw_data;
  assign xtal_rise = p.crystal_input & ~pp.crystal_input;
  assign vco_rise  = p.synth_vco & ~pp.synth_vco;
  assign pump_rise = p.pump_pulse & ~pp.pump_pulse;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] ref_cnt_q;
  logic [7:0] ref_cnt_d;
  logic [7:0] vco_cnt_q;
  logic [7:0] vco_cnt_d;
  logic [7:0] rdata_d;
  logic [7:0] status;
  acq_state_t state_q;
  acq_state_t state_d;

  assign status = {3'h0, low_gain_q, phase_only_q, framed_q,
                   mark_found_q, state_q != S_IDLE};

  // software writes count N-1 for ratio N
  always_comb begin
    cfg_d     = cfg_q;
    ref_cnt_d = ref_cnt_q;
    vco_cnt_d = vco_cnt_q;
    rdata_d   = 8'h00;
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CFG:     cfg_d = bus.wdata;
        ADDR_REF_DIV: ref_cnt_d = bus.wdata;
        ADDR_VCO_DIV: vco_cnt_d = bus.wdata;
        default:      cfg_d = cfg_q;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CFG:     rdata_d = cfg_q;
        ADDR_REF_DIV: rdata_d = ref_cnt_q;
        ADDR_VCO_DIV: rdata_d = vco_cnt_q;
        ADDR_STATUS:  rdata_d = status;
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q     <= CFG_RESET;
      ref_cnt_q <= REF_DIV_RESET;
      vco_cnt_q <= VCO_DIV_RESET;
      rdata_q   <= 8'h00;
    end else begin
      cfg_q     <= cfg_d;
      ref_cnt_q <= ref_cnt_d;
      vco_cnt_q <= vco_cnt_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // synthesizer dividers
  // ---------------------------------------------------------------
  logic       pres_q;
  logic       pres_d;
  logic [1:0] quart_q;
  logic [1:0] quart_d;
  logic       ref_tick;
  logic       vco_tick;

  // crystal must stay below the 200 MHz sampling rate by a wide margin
  always_comb begin
    pres_d  = xtal_rise ? ~pres_q : pres_q;
    quart_d = vco_rise ? quart_q + 2'h1 : quart_q;
  end

  assign ref_tick = cfg_q[CFG_HFCE_BIT] ? (xtal_rise & pres_q) : xtal_rise;
  assign vco_tick = vco_rise & (quart_q == 2'h3);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pres_q  <= 1'b0;
      quart_q <= 2'h0;
    end else begin
      pres_q  <= pres_d;
      quart_q <= quart_d;
    end
  end

  // 8-bit counts give ratios up to 256
  prog_divider #(.W(DIV_W)) u_ref_div (
    .clock   (clock),
    .rst     (rst),
    .tick    (ref_tick),
    .count   (ref_cnt_q),
    .pulse_q (ref_div_pulse)
  );

  prog_divider #(.W(DIV_W)) u_vco_div (
    .clock   (clock),
    .rst     (rst),
    .tick    (vco_tick),
    .count   (vco_cnt_q),
    .pulse_q (vco_div_pulse)
  );

  // ---------------------------------------------------------------
  // address mark detection
  // ---------------------------------------------------------------
  logic       search_ok;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic       armed_q;
  logic       armed_d;
  logic [1:0] hf_q;
  logic [1:0] hf_d;
  logic       mark_d;

  assign search_ok = p.mark_search_enable & ~p.sync_write_gate & ~p.encoder_enable;

  // a long gap marks the mark; short periods after it qualify it
  always_comb begin
    gap_d   = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
    armed_d = armed_q;
    hf_d    = hf_q;
    mark_d  = mark_found_q;
    if (!search_ok) begin
      armed_d = 1'b0;
      hf_d    = 2'h0;
      mark_d  = 1'b0;
    end else if (raw_pulse) begin
      gap_d = 8'h00;
      if (gap_q >= MARK_GAP) begin
        armed_d = 1'b1;
        hf_d    = 2'h0;
      end else if (armed_q && gap_q <= HF_MAX) begin
        hf_d = hf_q + 2'h1;
        if (hf_d == HF_NEEDED) begin
          mark_d  = 1'b1;
          armed_d = 1'b0;
        end
      end else begin
        hf_d = 2'h0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q        <= 8'h00;
      armed_q      <= 1'b0;
      hf_q         <= 2'h0;
      mark_found_q <= 1'b0;
    end else begin
      gap_q        <= gap_d;
      armed_q      <= armed_d;
      hf_q         <= hf_d;
      mark_found_q <= mark_d;
    end
  end

  // ---------------------------------------------------------------
  // acquisition sequencer
  // ---------------------------------------------------------------
  logic       mark_prev_q;
  logic       mark_rise;
  logic       soft_q;
  logic       soft_d;
  logic [6:0] lock_q;
  logic [6:0] lock_d;
  logic [6:0] lock_len;
  logic [1:0] pump_q;
  logic [1:0] pump_d;
  logic       phase_d;
  logic       gain_d;

  assign mark_rise = mark_found_q & ~mark_prev_q;

  always_comb begin
    case (cfg_q[CFG_LOCK_MSB:CFG_LOCK_LSB])
      2'h0:    lock_len = VLOCK_T0;
      2'h1:    lock_len = VLOCK_T1;
      2'h2:    lock_len = VLOCK_T2;
      default: lock_len = VLOCK_T3;
    endcase
  end

  always_comb begin
    state_d = state_q;
    soft_d  = soft_q;
    lock_d  = lock_q;
    pump_d  = pump_q;
    phase_d = phase_only_q;
    gain_d  = low_gain_q;
    case (state_q)
      S_IDLE: begin
        if (rg_rise || mark_rise) begin
          state_d = S_VLOCK;
          soft_d  = mark_rise & ~p.read_gate;
          lock_d  = 7'h01;
        end
      end
      S_VLOCK: begin
        lock_d = lock_q + 7'h01;
        if (lock_q >= lock_len) begin
          if (soft_q && !p.read_gate) begin
            state_d = S_IDLE;
          end else begin
            state_d = S_PUMP;
            phase_d = 1'b1;
            pump_d  = 2'h0;
          end
        end
      end
      S_PUMP: begin
        if (pump_rise) begin
          pump_d = pump_q + 2'h1;
          if (pump_d == PUMP_COUNT) begin
            gain_d  = 1'b1;
            state_d = S_TRACK;
          end
        end
      end
      S_TRACK: state_d = S_TRACK;
      default: state_d = S_IDLE;
    endcase
    if (state_q != S_IDLE && !(state_q == S_VLOCK && soft_q) && rg_fall) begin
      state_d = S_IDLE;
    end
    if (state_d == S_IDLE) begin
      phase_d = 1'b0;
      gain_d  = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q      <= S_IDLE;
      soft_q       <= 1'b0;
      lock_q       <= 7'h00;
      pump_q       <= 2'h0;
      phase_only_q <= 1'b0;
      low_gain_q   <= 1'b0;
      mark_prev_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      soft_q       <= soft_d;
      lock_q       <= lock_d;
      pump_q       <= pump_d;
      phase_only_q <= phase_d;
      low_gain_q   <= gain_d;
      mark_prev_q  <= mark_found_q;
    end
  end

  // ---------------------------------------------------------------
  // framing and read data
  // ---------------------------------------------------------------
  logic [8:0] shift_q;
  logic [8:0] shift_d;
  logic       framed_d;
  logic       rdat_d;

  always_comb begin
    shift_d  = {shift_q[7:0], raw_pulse};
    framed_d = framed_q;
    rdat_d   = 1'b0;
    if (!phase_only_q) begin
      framed_d = 1'b0;
    end else if (shift_q == SYNC_PATTERN) begin
      framed_d = 1'b1;
    end
    if (framed_q) begin
      rdat_d = shift_q[8];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_q     <= 9'h000;
      framed_q    <= 1'b0;
      read_data_q <= 1'b0;
    end else begin
      shift_q     <= shift_d;
      framed_q    <= framed_d;
      read_data_q <= rdat_d;
    end
  end

  // ---------------------------------------------------------------
  // recovered clock steering
  // ---------------------------------------------------------------
  logic       sel_q;
  logic       sel_d;
  logic       rclk_d;
  logic       src;
  logic       dst;
  logic       dst_rise;
  logic [3:0] pause_q;
  logic [3:0] pause_d;

  // a high phase runs out on the old source, then the output stops low
  // and moves only once the new source is low too: no runt pulse either way
  // pause counted in cycles of the new source, the window clock is unrelated
  always_comb begin
    sel_d    = sel_q;
    src      = sel_q ? p.sync_nrz_clk : p.synth_nrz_clk;
    dst      = phase_only_q ? p.sync_nrz_clk : p.synth_nrz_clk;
    dst_rise = dst & ~(phase_only_q ? pp.sync_nrz_clk : pp.synth_nrz_clk);
    rclk_d   = src;
    pause_d  = 4'h0;
    if (sel_q != phase_only_q) begin
      rclk_d  = rclk_q & src;
      pause_d = dst_rise ? pause_q + 4'h1 : pause_q;
      if (!rclk_q && !dst) begin
        sel_d = phase_only_q;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q   <= 1'b0;
      rclk_q  <= 1'b0;
      pause_q <= 4'h0;
    end else begin
      sel_q   <= sel_d;
      rclk_q  <= rclk_d;
      pause_q <= pause_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mark_gate: assert property (@(posedge clock) disable iff (rst)
    $rose(mark_found_q) |-> $past(search_ok))
    else $error("mark found without search enabled");

  a_mark_three: assert property (@(posedge clock) disable iff (rst)
    $rose(mark_found_q) |-> $past(hf_q) == 2'h2 && $past(raw_pulse))
    else $error("mark found before third period");

  a_start_seq: assert property (@(posedge clock) disable iff (rst)
    state_q == S_IDLE && (rg_rise || mark_rise) |=> state_q == S_VLOCK && lock_q == 7'h01)
    else $error("sequence did not start");

  a_soft_start: assert property (@(posedge clock) disable iff (rst)
    state_q == S_IDLE && mark_rise && !p.read_gate |=> soft_q)
    else $error("soft start not recorded");

  a_abort_seq: assert property (@(posedge clock) disable iff (rst)
    state_q == S_VLOCK && lock_q >= lock_len && soft_q && !p.read_gate
    |=> state_q == S_IDLE && !phase_only_q)
    else $error("mark sequence not aborted");

  a_lock_len: assert property (@(posedge clock) disable iff (rst)
    $rose(phase_only_q) |-> $past(lock_q) == $past(lock_len))
    else $error("velocity lock length wrong");

  a_phase_switch: assert property (@(posedge clock) disable iff (rst)
    state_q == S_VLOCK && lock_q >= lock_len && (p.read_gate || !soft_q) && !rg_fall
    |=> phase_only_q)
    else $error("phase lock not entered");

  a_low_gain: assert property (@(posedge clock) disable iff (rst)
    $rose(low_gain_q) |-> phase_only_q && $past(pump_q) == 2'h1 && $past(pump_rise))
    else $error("low gain before two pump pulses");

  a_release: assert property (@(posedge clock) disable iff (rst)
    state_q inside {S_PUMP, S_TRACK} && rg_fall |=> state_q == S_IDLE && !low_gain_q)
    else $error("read gate drop not honoured");

  a_framed: assert property (@(posedge clock) disable iff (rst)
    $rose(framed_q) |-> $past(shift_q) == SYNC_PATTERN && $past(phase_only_q))
    else $error("framed without sync pattern");

  a_rclk_pause: assert property (@(posedge clock) disable iff (rst)
    pause_q <= PAUSE_MAX)
    else $error("recovered clock paused too long");

endmodule // read_acquisition_sequencer

`default_nettype wire

/* sim/hdc_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----
// disk controller side
// ----
module hdc_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       mark_found,
  input  wire logic       hard_req,
  input  wire logic       soft_req,
  input  wire logic       answer,
  input  wire logic [4:0] answer_wait,
  output var  logic       read_gate,
  output var  logic       mark_search_enable
);
  logic [4:0] wait_q;
  logic       soft_gate_q;

  // a silent controller never answers, so the sequence must abort
  always @(posedge clock or posedge rst) begin
    if (rst || !soft_req) begin
      wait_q             <= 5'h00;
      soft_gate_q        <= 1'b0;
      mark_search_enable <= 1'b0;
    end else if (mark_found && answer && !soft_gate_q) begin
      wait_q <= wait_q + 5'h01;
      if (wait_q == answer_wait) begin
        soft_gate_q        <= 1'b1;
        mark_search_enable <= 1'b0;
      end
    end else if (!soft_gate_q) begin
      mark_search_enable <= 1'b1;
    end
  end

  assign read_gate = hard_req | soft_gate_q;
endmodule // hdc_model

`default_nettype wire

/* sim/read_acquisition_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none

module read_acquisition_sequencer_test import acq_pkg::*;;
  typedef struct {int kind; logic [7:0] cfg; logic [7:0] cnt; int exp;} row_t;
  row_t rows [9] = '{'{0, 8'h01, 8'h00, 60}, '{0, 8'h03, 8'h00, 72}, '{0, 8'h05, 8'h00, 84},
    '{0, 8'h07, 8'h00, 96}, '{1, 8'h07, 8'h04, 40}, '{1, 8'h06, 8'h04, 20},
    '{1, 8'h07, 8'hff, 2048}, '{2, 8'h07, 8'h35, 864}, '{2, 8'h07, 8'hff, 4096}};
  logic       clock, rst, hard_req, soft_req, answer, swg, pump, raw_man, stream;
  logic       read_gate, mark_search_enable, rclk_prev, armed, enc;
  logic       mark_found_q, phase_only_q, low_gain_q, rclk_q, read_data_q, framed_q;
  logic       ref_div_pulse, vco_div_pulse;
  logic [4:0] answer_wait;
  logic [7:0] tick, rdata_q, d;
  logic [1:0] ph;
  bus_req_t   bus;
  pins_t      pins;
  int         err_count, check_count, n, k, base, run, i;

  assign pins = '{read_gate: read_gate, mark_search_enable: mark_search_enable, sync_write_gate: swg,
    encoder_enable: enc, raw_data: stream ? (ph == 2'h2) : raw_man, crystal_input: tick[1],
    synth_vco: tick[1], pump_pulse: pump, synth_nrz_clk: tick[3], sync_nrz_clk: tick[2]};

  read_acquisition_sequencer #(.DIV_W(8)) read_acquisition_sequencer_inst (.clock(clock), .rst(rst),
    .bus(bus), .rdata_q(rdata_q), .pins(pins), .mark_found_q(mark_found_q), .phase_only_q(phase_only_q),
    .low_gain_q(low_gain_q), .rclk_q(rclk_q), .read_data_q(read_data_q), .framed_q(framed_q),
    .ref_div_pulse(ref_div_pulse), .vco_div_pulse(vco_div_pulse));

  hdc_model hdc_model_inst (.clock(clock), .rst(rst), .mark_found(mark_found_q), .hard_req(hard_req),
    .soft_req(soft_req), .answer(answer), .answer_wait(answer_wait), .read_gate(read_gate),
    .mark_search_enable(mark_search_enable));

  // ----
  // clocks, patterns, monitors
  // ----
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // slow pin clocks: the pins pass a two-flop synchroniser
  always @(posedge clock) begin
    tick <= tick + 8'h01;
    ph   <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
  end

  // runs of rclk never shorter than a half period, pauses bounded
  always @(posedge clock) begin
    if (rst) begin
      armed = 1'b0;
      run = 0;
    end else if (rclk_q !== rclk_prev) begin
      if (armed && run < 4) fail_at("rclk glitch");
      armed = 1'b1;
      run = 1;
    end else begin
      run++;
      if (run == 49) fail_at("rclk pause");
    end
    rclk_prev = rclk_q;
  end

  initial begin
    repeat (60000) @(posedge clock);
    fail_at("timeout");
    print_verdict();
  end

  // ----
  // tasks
  // ----
  task automatic fail_at(input string msg);
    err_count++;
    $display("FAIL %0t %s", $time, msg);
  endtask

  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) fail_at(msg);
  endtask

  task automatic check_span(input int got, input int lo, input int hi, input string msg);
    check_count++;
    if (got < lo || got > hi) fail_at(msg);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock) bus <= '0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock) bus <= '0;
    #1 v = rdata_q;
  endtask

  function automatic logic flag(input int w);
    case (w)
      0: return phase_only_q;
      1: return low_gain_q;
      2: return framed_q;
      3: return mark_found_q;
      4: return ref_div_pulse;
      5: return vco_div_pulse;
      default: return read_data_q;
    endcase
  endfunction

  task automatic wait_hi(input int w, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      #1;
      cnt++;
      if (w == 0 && phase_only_q !== 1'b1) check_bits({7'h00, framed_q | read_data_q}, 8'h00, "early frame");
    end while (flag(w) !== 1'b1 && cnt < lim);
  endtask

  task automatic count_edges(output int cnt);
    logic last;
    cnt = 0;
    last = rclk_q;
    repeat (96) begin
      @(posedge clock);
      #1;
      if (rclk_q === 1'b1 && last === 1'b0) cnt++;
      last = rclk_q;
    end
  endtask

  task automatic pump_once();
    @(posedge clock) pump <= 1'b1;
    repeat (3) @(posedge clock);
    pump <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // gap arms the detector, then pulses two cycles apart
  task automatic send_mark(input int pulses, input logic found);
    repeat (16) @(posedge clock);
    repeat (pulses) begin
      raw_man <= 1'b1;
      @(posedge clock) raw_man <= 1'b0;
      @(posedge clock);
    end
    wait_hi(3, 12, n);
    check_bits({7'h00, mark_found_q}, {7'h00, found}, "mark");
  endtask

  task automatic lock_row(input int len);
    @(posedge clock) hard_req <= 1'b1;
    stream <= 1'b1;
    wait_hi(0, 200, n);
    if (len == 60) base = n;
    check_span(n - len, 1, 6, "lock length");
    check_span(n - base, len - 60, len - 60, "lock step");
    pump_once();
    check_bits({7'h00, low_gain_q}, 8'h00, "gain one pump");
    pump_once();
    check_bits({7'h00, low_gain_q}, 8'h01, "gain two pumps");
    wait_hi(2, 60, k);
    check_bits({7'h00, framed_q}, 8'h01, "framing");
    wait_hi(6, 8, k);
    check_bits({7'h00, read_data_q}, 8'h01, "data");
    count_edges(k);
    check_span(k, 11, 13, "rclk vco");
    @(posedge clock) hard_req <= 1'b0;
    stream <= 1'b0;
    repeat (8) @(posedge clock);
    #1 check_bits({5'h00, phase_only_q, low_gain_q, framed_q}, 8'h00, "release");
    repeat (40) @(posedge clock);
    count_edges(k);
    check_span(k, 5, 7, "rclk ref");
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    rst = 1'b1;
    bus = '0;
    {hard_req, soft_req, answer, swg, pump, raw_man, stream, rclk_prev, armed, enc} = '0;
    answer_wait = 5'h00;
    tick = 8'h00;
    ph = 2'h0;
    {err_count, check_count, base, run} = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      bus_wr(ADDR_CFG, rows[i].cfg);
      if (rows[i].kind == 0) lock_row(rows[i].exp);
      else begin
        bus_wr(rows[i].kind == 1 ? ADDR_REF_DIV : ADDR_VCO_DIV, rows[i].cnt);
        repeat (3) wait_hi(rows[i].kind + 3, 5000, n);
        check_span(n, rows[i].exp, rows[i].exp, "divider");
      end
    end
    // soft sector, controller answers late
    answer <= 1'b1;
    answer_wait <= 5'h14;
    @(posedge clock) soft_req <= 1'b1;
    send_mark(3, 1'b0);
    send_mark(4, 1'b1);
    wait_hi(0, 130, n);
    check_span(n, 94, 100, "soft start");
    @(posedge clock) soft_req <= 1'b0;
    repeat (8) @(posedge clock);
    #1 check_bits({7'h00, phase_only_q}, 8'h00, "soft release");
    // silent controller
    answer <= 1'b0;
    @(posedge clock) soft_req <= 1'b1;
    send_mark(4, 1'b1);
    bus_rd(ADDR_STATUS, d);
    check_bits({7'h00, d[0]}, 8'h01, "busy");
    wait_hi(0, 110, n);
    check_bits({7'h00, phase_only_q}, 8'h00, "abort lock");
    bus_rd(ADDR_STATUS, d);
    check_bits({7'h00, d[0]}, 8'h00, "abort idle");
    @(posedge clock) soft_req <= 1'b0;
    // write path active blocks the mark search
    swg <= 1'b1;
    answer <= 1'b1;
    repeat (4) @(posedge clock);
    soft_req <= 1'b1;
    send_mark(4, 1'b0);
    swg <= 1'b0;
    enc <= 1'b1;
    send_mark(4, 1'b0);
    @(posedge clock) soft_req <= 1'b0;
    enc <= 1'b0;
    // second reset in mid-run
    @(posedge clock) rst <= 1'b1;
    repeat (12) @(posedge clock);
    #1 check_bits({2'h0, mark_found_q, phase_only_q, low_gain_q, rclk_q, read_data_q, framed_q}, 8'h00,
      "reset outputs");
    @(posedge clock) rst <= 1'b0;
    bus_wr(4'hf, 8'hff);
    bus_rd(ADDR_CFG, d);
    check_bits(d, CFG_RESET, "cfg reset");
    check_bits({7'h00, d[CFG_HFCE_BIT]}, 8'h01, "prescaler on");
    bus_rd(ADDR_REF_DIV, d);
    check_bits(d, REF_DIV_RESET, "ref reset");
    bus_rd(ADDR_VCO_DIV, d);
    check_bits(d, VCO_DIV_RESET, "vco reset");
    bus_rd(ADDR_STATUS, d);
    check_bits(d, 8'h00, "status idle");
    bus_rd(4'hf, d);
    check_bits(d, 8'h00, "unmapped");
    repeat (3) wait_hi(4, 100, n);
    check_span(n, 8, 8, "default prescale");
    count_edges(k);
    check_span(k, 5, 7, "rclk after reset");
    print_verdict();
  end
endmodule // read_acquisition_sequencer_test

`default_nettype wire
